// ### common/qsr_pkg.sv
// Constants and carrier types for the questionable status reporting block
package qsr_pkg;

	// Geometry of one status structure and of the whole tree
	localparam int QSR_WIDTH = 16;
	localparam int QSR_GROUPS = 5;
	localparam int QSR_SYNC_W = QSR_WIDTH * QSR_GROUPS;

	typedef logic [QSR_WIDTH-1:0] qsr_word_t;

	// Group select codes carried by a command
	localparam logic [2:0] QSR_GRP_SUMMARY = 3'h0;
	localparam logic [2:0] QSR_GRP_OVERLOAD = 3'h1;
	localparam logic [2:0] QSR_GRP_CONVERTER = 3'h2;
	localparam logic [2:0] QSR_GRP_LIMIT = 3'h3;
	localparam logic [2:0] QSR_GRP_MASKTEST = 3'h4;
	localparam logic [2:0] QSR_GRP_LAST = 3'h4;

	// Register part select codes carried by a command
	localparam logic [2:0] QSR_PART_STATE = 3'h0;
	localparam logic [2:0] QSR_PART_ENABLE = 3'h1;
	localparam logic [2:0] QSR_PART_EVENT = 3'h2;
	localparam logic [2:0] QSR_PART_FALL = 3'h3;
	localparam logic [2:0] QSR_PART_RISE = 3'h4;
	localparam logic [2:0] QSR_PART_PRESET = 3'h7;

	// Values after reset; a preset command reloads only the mask and event values
	localparam qsr_word_t QSR_RST_MASK = 16'h0000;
	localparam qsr_word_t QSR_RST_EVENT = 16'h0000;
	localparam qsr_word_t QSR_RST_STATE = 16'h0000;
	localparam logic [QSR_SYNC_W-1:0] QSR_RST_SYNC = 80'h0;

	// Summary bit of sub group g lands on top condition bit QSR_SUB_BASE + g - 1
	localparam int QSR_SUB_BASE = 0;

	// Command from the remote-control host, one cycle per command
	typedef struct packed {
		logic valid;
		logic write;
		logic [2:0] group;
		logic [2:0] part;
		qsr_word_t wdata;
	} qsr_cmd_t;

	// Answer to a command, one cycle after it
	typedef struct packed {
		logic valid;
		logic err;
		qsr_word_t rdata;
	} qsr_rsp_t;

	// State of one status structure
	typedef struct packed {
		qsr_word_t state;
		qsr_word_t enable;
		qsr_word_t event_bits;
		qsr_word_t fall;
		qsr_word_t rise;
		logic sum;
		logic sum_rise;
	} qsr_unit_st_t;

	// State of the pin synchroniser
	typedef struct packed {
		logic [QSR_SYNC_W-1:0] s1;
		logic [QSR_SYNC_W-1:0] s2;
		logic [QSR_SYNC_W-1:0] s3;
		logic [QSR_SYNC_W-1:0] held;
	} qsr_sync_st_t;

	// State of the top level
	typedef struct packed {
		qsr_rsp_t rsp;
	} qsr_top_st_t;

endpackage

// ### hdl/qsr_sync.sv
// Three-stage synchroniser with agreement filter for the condition pins
`timescale 1ns/1ps
module qsr_sync (
	// Clock and reset
	input wire logic clk,
	input wire logic rstn,
	// Raw pins and filtered result
	input wire logic [qsr_pkg::QSR_SYNC_W-1:0] din,
	output logic [qsr_pkg::QSR_SYNC_W-1:0] dout
);
	import qsr_pkg::*;

	qsr_sync_st_t st_r;
	qsr_sync_st_t st_nxt;

	// Stage one feeds stage two only; a change counts once stages two and three agree
	always_comb begin
		st_nxt = st_r;
		st_nxt.s1 = din;
		st_nxt.s2 = st_r.s1;
		st_nxt.s3 = st_r.s2;
		st_nxt.held = (~(st_r.s2 ^ st_r.s3) & st_r.s3) | ((st_r.s2 ^ st_r.s3) & st_r.held);
	end

	// State register
	always_ff @(posedge clk) begin
		if (!rstn) begin
			st_r <= '{s1: QSR_RST_SYNC, s2: QSR_RST_SYNC, s3: QSR_RST_SYNC, held: QSR_RST_SYNC};
		end else begin
			st_r <= st_nxt;
		end
	end

	assign dout = st_r.held;

endmodule // qsr_sync

// ### hdl/qsr_unit.sv
// One status structure: condition, transition filters, latched events, enable, summary
`timescale 1ns/1ps
module qsr_unit (
	// Clock and reset
	input wire logic clk,
	input wire logic rstn,
	// Current condition bits, same clock domain
	input wire qsr_pkg::qsr_word_t cond,
	// Host access
	input wire logic wr_en,
	input wire logic [2:0] wr_part,
	input wire qsr_pkg::qsr_word_t wr_data,
	input wire logic rd_clear,
	input wire logic preset,
	// Register contents
	output qsr_pkg::qsr_word_t current_state_bits,
	output qsr_pkg::qsr_word_t summary_enable_mask,
	output qsr_pkg::qsr_word_t latched_event_bits,
	output qsr_pkg::qsr_word_t falling_edge_filter,
	output qsr_pkg::qsr_word_t rising_edge_filter,
	// Summary level and its one-cycle rising pulse
	output logic summary,
	output logic summary_rise
);
	import qsr_pkg::*;

	qsr_unit_st_t st_r;
	qsr_unit_st_t st_nxt;
	qsr_word_t rise_hit;
	qsr_word_t fall_hit;

	// Edge detection against the stored condition, gated by the filters
	assign rise_hit = cond & ~st_r.state & st_r.rise;
	assign fall_hit = ~cond & st_r.state & st_r.fall;

	// Next state; a new event in the clearing cycle survives the clear
	always_comb begin
		st_nxt = st_r;
		st_nxt.state = cond;
		if (wr_en && wr_part == QSR_PART_ENABLE) begin
			st_nxt.enable = wr_data;
		end
		if (wr_en && wr_part == QSR_PART_FALL) begin
			st_nxt.fall = wr_data;
		end
		if (wr_en && wr_part == QSR_PART_RISE) begin
			st_nxt.rise = wr_data;
		end
		if (preset) begin
			st_nxt.enable = QSR_RST_MASK;
			st_nxt.fall = QSR_RST_MASK;
			st_nxt.rise = QSR_RST_MASK;
		end
		st_nxt.event_bits = ((rd_clear || preset) ? QSR_RST_EVENT : st_r.event_bits)
			| rise_hit | fall_hit;
		st_nxt.sum = |(st_nxt.event_bits & st_nxt.enable);
		st_nxt.sum_rise = st_nxt.sum & ~st_r.sum;
	end

	// State register
	always_ff @(posedge clk) begin
		if (!rstn) begin
			st_r <= '{state: QSR_RST_STATE, enable: QSR_RST_MASK, event_bits: QSR_RST_EVENT,
				fall: QSR_RST_MASK, rise: QSR_RST_MASK, sum: 1'b0, sum_rise: 1'b0};
		end else begin
			st_r <= st_nxt;
		end
	end

	// Contents straight from flip-flops
	assign current_state_bits = st_r.state;
	assign summary_enable_mask = st_r.enable;
	assign latched_event_bits = st_r.event_bits;
	assign falling_edge_filter = st_r.fall;
	assign rising_edge_filter = st_r.rise;
	assign summary = st_r.sum;
	assign summary_rise = st_r.sum_rise;

endmodule // qsr_unit

// ### hdl/qsr_top.sv
// Questionable status reporting tree: summary structure fed by four sub structures
`timescale 1ns/1ps
module qsr_top (
	// Clock and reset
	input wire logic REF_CLK,
	input wire logic RSTN,
	// Host command and answer
	input wire qsr_pkg::qsr_cmd_t CMD,
	output qsr_pkg::qsr_rsp_t RSP,
	// Condition pins, asynchronous to REF_CLK
	input wire qsr_pkg::qsr_word_t COND_SUMMARY,
	input wire qsr_pkg::qsr_word_t COND_OVERLOAD,
	input wire qsr_pkg::qsr_word_t COND_CONVERTER,
	input wire qsr_pkg::qsr_word_t COND_LIMIT,
	input wire qsr_pkg::qsr_word_t COND_MASKTEST,
	// Summary toward the status byte
	output logic QSR_SUMMARY,
	output logic QSR_SUMMARY_RISE,
	output logic [qsr_pkg::QSR_GROUPS-1:0] GROUP_SUMMARY
);
	import qsr_pkg::*;

	qsr_top_st_t st_r;
	qsr_top_st_t st_nxt;

	logic [QSR_SYNC_W-1:0] pins_raw;
	logic [QSR_SYNC_W-1:0] pins_sync;
	qsr_word_t sub_vec;
	qsr_word_t cond_w [QSR_GROUPS];
	qsr_word_t state_w [QSR_GROUPS];
	qsr_word_t enable_w [QSR_GROUPS];
	qsr_word_t event_w [QSR_GROUPS];
	qsr_word_t fall_w [QSR_GROUPS];
	qsr_word_t rise_w [QSR_GROUPS];
	logic [QSR_GROUPS-1:0] sum_w;
	logic [QSR_GROUPS-1:0] sum_rise_w;
	logic [QSR_GROUPS-1:0] wr_en_w;
	logic [QSR_GROUPS-1:0] rd_clear_w;
	logic grp_ok;
	logic part_wr_ok;
	logic part_rd_ok;
	logic is_preset;
	logic cmd_ok;
	qsr_word_t rd_mux;

	// All condition pins share one synchroniser; group g occupies slice g
	assign pins_raw = {COND_MASKTEST, COND_LIMIT, COND_CONVERTER, COND_OVERLOAD, COND_SUMMARY};

	qsr_sync u_sync (
		.clk(REF_CLK),
		.rstn(RSTN),
		.din(pins_raw),
		.dout(pins_sync)
	);

	// Sub summaries are already on REF_CLK, so they join the top condition unsynchronised
	always_comb begin
		sub_vec = QSR_RST_STATE;
		for (int g = 1; g < QSR_GROUPS; g++) begin
			sub_vec[QSR_SUB_BASE + g - 1] = sum_w[g];
		end
	end

	// Command decode shared by all groups
	assign is_preset = CMD.write && (CMD.part == QSR_PART_PRESET);
	assign grp_ok = (CMD.group <= QSR_GRP_LAST);
	assign part_wr_ok = (CMD.part == QSR_PART_ENABLE) || (CMD.part == QSR_PART_FALL)
		|| (CMD.part == QSR_PART_RISE);
	assign part_rd_ok = (CMD.part <= QSR_PART_RISE);
	assign cmd_ok = is_preset || (grp_ok && (CMD.write ? part_wr_ok : part_rd_ok));

	// Five identical structures, the first one being the summary level
	for (genvar g = 0; g < QSR_GROUPS; g++) begin : g_unit
		if (g == 0) begin : g_top
			assign cond_w[g] = pins_sync[g*QSR_WIDTH +: QSR_WIDTH] | sub_vec;
		end else begin : g_sub
			assign cond_w[g] = pins_sync[g*QSR_WIDTH +: QSR_WIDTH];
		end

		// Writes to read-only parts never reach a structure
		assign wr_en_w[g] = CMD.valid && CMD.write && !is_preset && part_wr_ok
			&& (CMD.group == 3'(g));
		// Only an event read clears; a condition read has no side effect
		assign rd_clear_w[g] = CMD.valid && !CMD.write && (CMD.part == QSR_PART_EVENT)
			&& (CMD.group == 3'(g));

		qsr_unit u_unit (
			.clk(REF_CLK),
			.rstn(RSTN),
			.cond(cond_w[g]),
			.wr_en(wr_en_w[g]),
			.wr_part(CMD.part),
			.wr_data(CMD.wdata),
			.rd_clear(rd_clear_w[g]),
			.preset(CMD.valid && is_preset),
			.current_state_bits(state_w[g]),
			.summary_enable_mask(enable_w[g]),
			.latched_event_bits(event_w[g]),
			.falling_edge_filter(fall_w[g]),
			.rising_edge_filter(rise_w[g]),
			.summary(sum_w[g]),
			.summary_rise(sum_rise_w[g])
		);
	end

	// Read data picks the addressed part; the event value is the one before clearing
	always_comb begin
		rd_mux = QSR_RST_STATE;
		for (int g = 0; g < QSR_GROUPS; g++) begin
			if (CMD.group == 3'(g)) begin
				case (CMD.part)
					QSR_PART_STATE: begin
						rd_mux = state_w[g];
					end
					QSR_PART_ENABLE: begin
						rd_mux = enable_w[g];
					end
					QSR_PART_EVENT: begin
						rd_mux = event_w[g];
					end
					QSR_PART_FALL: begin
						rd_mux = fall_w[g];
					end
					QSR_PART_RISE: begin
						rd_mux = rise_w[g];
					end
					default: begin
						rd_mux = QSR_RST_STATE;
					end
				endcase
			end
		end
	end

	// Answer one cycle after each command; writes and errors return zero data
	always_comb begin
		st_nxt = st_r;
		st_nxt.rsp.valid = CMD.valid;
		st_nxt.rsp.err = CMD.valid && !cmd_ok;
		if (CMD.valid && cmd_ok && !CMD.write) begin
			st_nxt.rsp.rdata = rd_mux;
		end else begin
			st_nxt.rsp.rdata = QSR_RST_STATE;
		end
	end

	// State register
	always_ff @(posedge REF_CLK) begin
		if (!RSTN) begin
			st_r <= '{rsp: '{valid: 1'b0, err: 1'b0, rdata: QSR_RST_STATE}};
		end else begin
			st_r <= st_nxt;
		end
	end

	// Outputs, all from flip-flops
	assign RSP = st_r.rsp;
	assign QSR_SUMMARY = sum_w[0];
	assign QSR_SUMMARY_RISE = sum_rise_w[0];
	assign GROUP_SUMMARY = sum_w;

endmodule // qsr_top

// ### verification/qsr_top_sva.sv
// Concurrent checks on the status reporting top level
`timescale 1ns/1ps
module qsr_top_sva (
	// Clock and reset
	input wire logic REF_CLK,
	input wire logic RSTN,
	// Command and answer
	input wire qsr_pkg::qsr_cmd_t CMD,
	input wire qsr_pkg::qsr_rsp_t RSP,
	// Summary toward the status byte
	input wire logic QSR_SUMMARY,
	input wire logic QSR_SUMMARY_RISE
);
	import qsr_pkg::*;
	default clocking @(posedge REF_CLK); endclocking
	default disable iff (!RSTN);
	// A write to an enable part followed at once by a read of it
	sequence s_wr_rd_en;
		CMD.valid && CMD.write && CMD.part == QSR_PART_ENABLE && CMD.group <= QSR_GRP_LAST ##1
		CMD.valid && !CMD.write && CMD.part == QSR_PART_ENABLE && CMD.group == $past(CMD.group);
	endsequence
	chk_rsp_one_cycle: assert property (CMD.valid |=> RSP.valid)
		else $error("no answer one cycle after command");
	chk_rsp_no_extra: assert property (!CMD.valid |=> !RSP.valid)
		else $error("answer without command");
	chk_state_ro: assert property (CMD.valid && CMD.write && CMD.part == QSR_PART_STATE
		|=> RSP.err)
		else $error("write to condition part accepted");
	chk_event_ro: assert property (CMD.valid && CMD.write && CMD.part == QSR_PART_EVENT
		|=> RSP.err)
		else $error("write to event part accepted");
	chk_bad_group: assert property (CMD.valid && CMD.group > QSR_GRP_LAST
		&& CMD.part != QSR_PART_PRESET |=> RSP.err)
		else $error("unknown group accepted");
	chk_mask_readback: assert property (s_wr_rd_en |=> RSP.rdata == $past(CMD.wdata, 2))
		else $error("enable mask not stored");
	chk_write_quiet: assert property (CMD.valid && CMD.write |=> RSP.rdata == 16'h0000)
		else $error("write answered with data");
	chk_rise_pulse: assert property ($rose(QSR_SUMMARY) |-> ##[0:1] QSR_SUMMARY_RISE)
		else $error("summary rise not reported");
	chk_rise_single: assert property (QSR_SUMMARY_RISE |=> !QSR_SUMMARY_RISE)
		else $error("rise pulse longer than one cycle");
	// Main scenarios reached
	cov_refused: cover property (RSP.valid && RSP.err);
	cov_rise: cover property (QSR_SUMMARY_RISE);
	cov_evt_read: cover property (CMD.valid && !CMD.write && CMD.part == QSR_PART_EVENT);
endmodule // qsr_top_sva
bind qsr_top qsr_top_sva i_qsr_top_sva (.REF_CLK(REF_CLK), .RSTN(RSTN), .CMD(CMD), .RSP(RSP),
	.QSR_SUMMARY(QSR_SUMMARY), .QSR_SUMMARY_RISE(QSR_SUMMARY_RISE));

// ### verification/qsr_host.sv
// Behavioural remote-control host issuing status commands
`timescale 1ns/1ps
module qsr_host (
	// Clock
	input wire logic clk,
	// Command toward the block
	output qsr_pkg::qsr_cmd_t cmd
);
	import qsr_pkg::*;
	// Quiet until the first command
	initial cmd = '0;
	// Present just after an edge, hold over the taking edge; back to back allowed
	task automatic send(input logic w, input logic [2:0] g, input logic [2:0] p, input qsr_word_t d);
		#1 cmd = '{valid: 1'b1, write: w, group: g, part: p, wdata: d};
		@(posedge clk);
	endtask
	// Idle data toggles so a stale word is never mistaken for a command
	task automatic idle(input int n);
		// One assignment, so the command word changes once in this time step
		#1 cmd = '{valid: 1'b0, write: cmd.write, group: cmd.group, part: cmd.part,
			wdata: ~cmd.wdata};
		repeat (n) @(posedge clk);
	endtask
endmodule // qsr_host

// ### verification/test_qsr_top.sv
// Self-checking bench for the questionable status reporting tree
`timescale 1ns/1ps
module test_qsr_top;
	import qsr_pkg::*;
	logic REF_CLK = 1'b0;
	logic RSTN = 1'b0;
	qsr_cmd_t cmd;
	qsr_rsp_t rsp;
	qsr_word_t cond [QSR_GROUPS] = '{default: '0};
	qsr_word_t v;
	logic qsr_sum;
	logic qsr_rise;
	logic [QSR_GROUPS-1:0] grp_sum;
	logic rise_seen = 1'b0;
	logic [16:0] expq [$];
	int mismatches = 0;
	int check_count = 0;
	int seed = 785;
	// 100 MHz clock
	initial begin
		forever #5 REF_CLK = ~REF_CLK;
	end
	qsr_host i_qsr_host (.clk(REF_CLK), .cmd(cmd));
	qsr_top i_qsr_top (.REF_CLK(REF_CLK), .RSTN(RSTN), .CMD(cmd), .RSP(rsp),
		.COND_SUMMARY(cond[0]), .COND_OVERLOAD(cond[1]), .COND_CONVERTER(cond[2]),
		.COND_LIMIT(cond[3]), .COND_MASKTEST(cond[4]), .QSR_SUMMARY(qsr_sum),
		.QSR_SUMMARY_RISE(qsr_rise), .GROUP_SUMMARY(grp_sum));
	task automatic check(input logic [16:0] seen, input logic [16:0] exp);
		check_count++;
		if (seen !== exp) begin
			mismatches++;
			$display("Error at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic summarize();
		// An answer that never came leaves its note behind and counts against the run
		mismatches += expq.size();
		$display("checks %0d mismatches %0d", check_count, mismatches);
		if (mismatches == 0 && check_count > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	// Note the expected answer {err, rdata}, then issue the command
	task automatic cmd_x(input logic w, input logic [2:0] g, input logic [2:0] p, input qsr_word_t d,
		input logic [16:0] e);
		expq.push_back(e);
		i_qsr_host.send(w, g, p, d);
	endtask
	task automatic rd(input logic [2:0] g, input logic [2:0] p, input qsr_word_t e);
		cmd_x(1'b0, g, p, 16'h0000, {1'b0, e});
	endtask
	task automatic wr(input logic [2:0] g, input logic [2:0] p, input qsr_word_t d);
		cmd_x(1'b1, g, p, d, 17'h00000);
	endtask
	// Masks and events of every group read zero
	task automatic all_zero();
		for (int g = 0; g < QSR_GROUPS; g++) begin
			for (int p = 1; p < 5; p++) rd(g[2:0], p[2:0], 16'h0000);
		end
	endtask
	// Pins change only with the bus idle; the synchroniser needs several edges
	task automatic pin(input int g, input qsr_word_t val);
		i_qsr_host.idle(0);
		cond[g] = val;
		repeat (8) @(posedge REF_CLK);
	endtask
	// Answers are compared against the oldest note; a stray answer always mismatches
	always @(negedge REF_CLK) begin
		if (qsr_rise === 1'b1) rise_seen = 1'b1;
		if (rsp.valid === 1'b1) check({rsp.err, rsp.rdata},
			expq.size() ? expq.pop_front() : 17'h1FFFF);
	end
	initial begin
		#200000;
		mismatches++;
		summarize();
	end
	initial begin
		repeat (2) @(posedge REF_CLK);
		#1 RSTN = 1'b1;
		@(posedge REF_CLK);
		all_zero();
		$display("reset values done");
		for (int g = 0; g < QSR_GROUPS; g++) begin
			for (int p = 1; p < 5; p++) begin
				v = 16'($random(seed));
				if (p != 2) wr(g[2:0], p[2:0], v);
				if (p != 2) rd(g[2:0], p[2:0], v);
			end
		end
		wr(3'h5, QSR_PART_PRESET, 16'h0000);
		all_zero();
		$display("mask storage done");
		wr(3'h1, QSR_PART_RISE, 16'h0018);
		wr(3'h1, QSR_PART_FALL, 16'h0008);
		pin(1, 16'hFFFF);
		rd(3'h1, QSR_PART_STATE, 16'hFFFF);
		rd(3'h1, QSR_PART_STATE, 16'hFFFF);
		rd(3'h1, QSR_PART_EVENT, 16'h0018);
		rd(3'h1, QSR_PART_EVENT, 16'h0000);
		pin(1, 16'hFFF7);
		rd(3'h1, QSR_PART_EVENT, 16'h0008);
		cmd_x(1'b1, 3'h1, QSR_PART_STATE, 16'h1234, 17'h10000);
		cmd_x(1'b1, 3'h1, QSR_PART_EVENT, 16'hFFFF, 17'h10000);
		cmd_x(1'b0, 3'h5, QSR_PART_ENABLE, 16'h0000, 17'h10000);
		cmd_x(1'b0, 3'h1, 3'h6, 16'h0000, 17'h10000);
		rd(3'h1, QSR_PART_STATE, 16'hFFF7);
		rd(3'h1, QSR_PART_EVENT, 16'h0000);
		$display("filters and events done");
		wr(3'h0, QSR_PART_RISE, 16'h0002);
		wr(3'h0, QSR_PART_ENABLE, 16'h0002);
		wr(3'h2, QSR_PART_RISE, 16'h0001);
		pin(2, 16'h0001);
		// Summary levels are looked at mid-cycle, away from the edge that launches them
		@(negedge REF_CLK);
		check(17'(grp_sum), 17'h00000);
		@(posedge REF_CLK);
		wr(3'h2, QSR_PART_ENABLE, 16'h0001);
		i_qsr_host.idle(6);
		@(negedge REF_CLK);
		check(17'(grp_sum), 17'h00005);
		check(17'(qsr_sum), 17'h00001);
		check(17'(rise_seen), 17'h00001);
		@(posedge REF_CLK);
		rd(3'h0, QSR_PART_EVENT, 16'h0002);
		rd(3'h2, QSR_PART_EVENT, 16'h0001);
		i_qsr_host.idle(3);
		$display("summary chain done");
		summarize();
	end
endmodule // test_qsr_top
